// *** design/cpu_clock_mode_select.sv ***
/*
  CPU clock mode select: latches the reset configuration from the
  upper port-0 byte during a long hardware reset, generates the CPU
  clock in direct or prescaler mode, and reports state over APB.
  Assumes all inputs are synchronous to MCLK and that LONG_RESET is
  a level held for at least one MCLK edge.
*/
// Behaviour
// - Clock mode comes from bits 7..5 of the reset configuration latch.
// - Long hardware reset loads the latch from the upper port-0 byte pins.
// - Mode top bit zero: PLL off, CPU clock follows oscillator directly.
// - Mode top bit one: CPU clock is oscillator divided by two.
// - Either CPU clock edge may start work; edge spacing is the phase time.
// - Prescaler mode: each phase lasts exactly one oscillator period.
// - Direct mode: phases follow duty cycle; two phases span one period.
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_mode_select
  import clkmode_pkg::*;
(
  input  wire logic          MCLK,
  input  wire logic          RST_N,
  // Long hardware reset level and configuration pins
  input  wire logic          LONG_RESET,
  input  wire logic [7:0]    PORT0_UPPER_BYTE,
  input  wire logic          OSC_IN,
  // APB slave
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [AW-1:0] PADDR,
  input  wire logic [DW-1:0] PWDATA,
  output logic [DW-1:0]      PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  // Clock results
  output logic               CPU_CLK,
  output logic               PHASE_EDGE,
  output logic               PLL_DISABLE,
  output logic               DIRECT_MODE,
  output logic               MODE_VALID
);

  ////////////////////////////////////////////////////////////////////
  // Configuration capture

  typedef enum logic [1:0] {
    CAP_WAIT,
    CAP_LOAD,
    CAP_HELD
  } cap_state_t;

  cap_state_t         cap_reg;
  cap_state_t         cap_next;
  logic [LATCH_W-1:0] reset_config_latch_reg;
  logic [LATCH_W-1:0] reset_config_latch_next;

  // Capture sequence: any long reset reloads, otherwise hold
  always_comb begin
    cap_next = cap_reg;
    case (cap_reg)
      CAP_WAIT: begin
        if (LONG_RESET) begin
          cap_next = CAP_LOAD;
        end
      end
      CAP_LOAD: begin
        if (!LONG_RESET) begin
          cap_next = CAP_HELD;
        end
      end
      CAP_HELD: begin
        if (LONG_RESET) begin
          cap_next = CAP_LOAD;
        end
      end
      default: cap_next = CAP_WAIT;
    endcase
  end

  // Pins are sampled on clock edges, never under the async reset;
  // the value of the last edge with LONG_RESET high is kept
  assign reset_config_latch_next = LONG_RESET ? PORT0_UPPER_BYTE
                                              : reset_config_latch_reg;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cap_reg                <= CAP_WAIT;
      reset_config_latch_reg <= LATCH_RST;
    end else begin
      cap_reg                <= cap_next;
      reset_config_latch_reg <= reset_config_latch_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mode decode

  // Only the top bit of the field matters; the lower two are ignored
  wire [MODE_MSB-MODE_LSB:0] mode_field =
    reset_config_latch_reg[MODE_MSB:MODE_LSB];
  wire       mode_top = mode_field[MODE_MSB-MODE_LSB];
  clk_mode_t mode;
  assign mode = mode_top ? MODE_PRESCALE : MODE_DIRECT;

  // Clock stays low until a configuration has been latched
  wire clk_run = (cap_reg == CAP_HELD);

  ////////////////////////////////////////////////////////////////////
  // Control register and APB decode

  logic [CTRL_W-1:0] ctrl_reg;
  logic [CTRL_W-1:0] ctrl_next;
  apb_req_t          req;

  assign req.addr  = PADDR;
  assign req.write = PWRITE;
  assign req.wdata = PWDATA;

  wire setup    = PSEL & ~PENABLE;
  wire access   = PSEL & PENABLE & PREADY;
  wire hit_lat  = req.addr == OFS_LATCH;
  wire hit_st   = req.addr == OFS_STATUS;
  wire hit_ctl  = req.addr == OFS_CTRL;
  wire hit_tcl  = req.addr == OFS_TCL;
  wire hit_pair = req.addr == OFS_PAIR;
  wire hit_edg  = req.addr == OFS_EDGES;
  wire mapped   = hit_lat | hit_st | hit_ctl | hit_tcl | hit_pair | hit_edg;
  // Only the control word is writable; latch is read only
  wire wr_ok    = hit_ctl;
  wire bad      = req.write ? ~wr_ok : ~mapped;
  wire ctl_wr   = access & req.write & hit_ctl;

  // Clear bit is self-clearing: it acts once per write of one
  assign ctrl_next = ctl_wr ? req.wdata[CTRL_W-1:0]
                            : (ctrl_reg & ~(CTRL_W'(1) << CTRL_CLR));

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= CTRL_RST;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Clock generation and phase measurement

  logic        cpu_clk_w;
  logic        edge_w;
  logic        strobe_w;
  phase_meas_t meas;

  clock_phase_gen u_gen (
    .clk        (MCLK),
    .rst_n      (RST_N),
    .run        (clk_run),
    .mode       (mode),
    .osc_in     (OSC_IN),
    .strobe_en  (ctrl_reg[CTRL_STROBE]),
    .cpu_clk    (cpu_clk_w),
    .edge_pulse (edge_w),
    .strobe     (strobe_w)
  );

  phase_timer #(
    .W (PH_W)
  ) u_timer (
    .clk        (MCLK),
    .rst_n      (RST_N),
    .clr        (ctrl_reg[CTRL_CLR]),
    .edge_pulse (edge_w),
    .tcl_reg    (meas.clock_phase_time),
    .pair_reg   (meas.pair),
    .edges_reg  (meas.edges)
  );

  ////////////////////////////////////////////////////////////////////
  // Read data and status

  logic [DW-1:0] status_w;
  logic [DW-1:0] rdata_w;

  // Status word built bit by bit; unused bits read as zero
  always_comb begin
    status_w             = ZERO_WORD;
    // Gated like the pins, so nothing claims a mode before a capture
    status_w[ST_DIRECT]  = clk_run & (mode == MODE_DIRECT);
    status_w[ST_PLL_OFF] = clk_run & (mode == MODE_DIRECT);
    status_w[ST_CPU_CLK] = cpu_clk_w;
    status_w[ST_VALID]   = clk_run;
  end

  // Read mux; narrow fields sit in the low bits
  always_comb begin
    rdata_w = ZERO_WORD;
    if (hit_lat) begin
      rdata_w = DW'(reset_config_latch_reg);
    end else if (hit_st) begin
      rdata_w = status_w;
    end else if (hit_ctl) begin
      rdata_w = DW'(ctrl_reg);
    end else if (hit_tcl) begin
      rdata_w = DW'(meas.clock_phase_time);
    end else if (hit_pair) begin
      rdata_w = DW'(meas.pair);
    end else if (hit_edg) begin
      rdata_w = DW'(meas.edges);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registered APB answer: ready in the first access cycle

  // Answer computed in setup so every APB output is a flop
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= ZERO_WORD;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup & bad;
      PRDATA  <= (setup & ~req.write & mapped) ? rdata_w : ZERO_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Clock result outputs

  // Status pins are registered; they set only after a capture and clear when a long reset starts
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      PLL_DISABLE <= 1'b0;
      DIRECT_MODE <= 1'b0;
      MODE_VALID  <= 1'b0;
    end else begin
      PLL_DISABLE <= clk_run & (mode == MODE_DIRECT);
      DIRECT_MODE <= clk_run & (mode == MODE_DIRECT);
      MODE_VALID  <= clk_run;
    end
  end

  // These come straight from flops inside the generator
  assign CPU_CLK    = cpu_clk_w;
  assign PHASE_EDGE = strobe_w;

endmodule : cpu_clock_mode_select
`default_nettype wire

// *** design/clkmode_pkg.sv ***
/*
  Constants and types for the CPU clock mode block.
  Assumes an APB slave with 8-bit byte addresses and 32-bit data.
*/
package clkmode_pkg;

  // APB shape
  localparam int AW = 8;
  localparam int DW = 32;

  // Register byte offsets
  localparam logic [AW-1:0] OFS_LATCH  = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AW-1:0] OFS_CTRL   = 8'h08;
  localparam logic [AW-1:0] OFS_TCL    = 8'h0C;
  localparam logic [AW-1:0] OFS_PAIR   = 8'h10;
  localparam logic [AW-1:0] OFS_EDGES  = 8'h14;

  // Latch layout: mode field in bits 7..5
  localparam int LATCH_W   = 8;
  localparam int MODE_MSB  = 7;
  localparam int MODE_LSB  = 5;
  localparam logic [LATCH_W-1:0] LATCH_RST = 8'h00;

  // Status bits
  localparam int ST_DIRECT  = 0;
  localparam int ST_PLL_OFF = 1;
  localparam int ST_CPU_CLK = 2;
  localparam int ST_VALID   = 3;

  // Control bits and reset value
  localparam int CTRL_W      = 2;
  localparam int CTRL_STROBE = 0;
  localparam int CTRL_CLR    = 1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h1;

  // Phase measurement width
  localparam int PH_W = 16;

  localparam logic [DW-1:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic {
    MODE_DIRECT,
    MODE_PRESCALE
  } clk_mode_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic          write;
    logic [DW-1:0] wdata;
  } apb_req_t;

  typedef struct packed {
    logic [PH_W-1:0] clock_phase_time;
    logic [PH_W-1:0] pair;
    logic [PH_W-1:0] edges;
  } phase_meas_t;

endpackage : clkmode_pkg

// *** design/clock_phase_gen.sv ***
/*
  CPU clock generator: direct drive or 2:1 prescale of the
  oscillator input. Assumes OSC_IN is sampled synchronously to clk,
  so clk must run well above the oscillator rate.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_phase_gen
  import clkmode_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      run,
  input  wire clk_mode_t mode,
  input  wire logic      osc_in,
  input  wire logic      strobe_en,
  output logic           cpu_clk,
  output logic           edge_pulse,
  output logic           strobe
);

  logic osc_q;
  logic cpu_next;
  wire  osc_rise = osc_in & ~osc_q;
  wire  changed  = cpu_next != cpu_clk;

  // Next CPU clock level; held low while not running
  always_comb begin
    case (mode)
      MODE_DIRECT:   cpu_next = osc_in;
      MODE_PRESCALE: cpu_next = cpu_clk ^ osc_rise;
      default:       cpu_next = 1'b0;
    endcase
    if (!run) begin
      cpu_next = 1'b0;
    end
  end

  // Every CPU clock edge closes one clock phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_q      <= 1'b0;
      cpu_clk    <= 1'b0;
      edge_pulse <= 1'b0;
      strobe     <= 1'b0;
    end else begin
      osc_q      <= osc_in;
      cpu_clk    <= cpu_next;
      edge_pulse <= changed;
      strobe     <= changed & strobe_en;
    end
  end

endmodule : clock_phase_gen
`default_nettype wire

// *** design/phase_timer.sv ***
/*
  Measures the length of each CPU clock phase and of the last two
  phases together, in clk cycles. Assumes one edge pulse per phase.
*/
`timescale 1ns/1ps
`default_nettype none
module phase_timer
  import clkmode_pkg::*;
#(
  parameter int W = PH_W
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          clr,
  input  wire logic          edge_pulse,
  output logic [W-1:0]       tcl_reg,
  output logic [W-1:0]       pair_reg,
  output logic [W-1:0]       edges_reg
);

  logic [W-1:0] cnt_reg;
  // Saturate so a stopped clock does not wrap to a short phase
  wire          sat    = &cnt_reg;
  wire  [W-1:0] len    = sat ? cnt_reg : W'(cnt_reg + 1'b1);
  wire  [W:0]   pair_w = {1'b0, len} + {1'b0, tcl_reg};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg   <= '0;
      tcl_reg   <= '0;
      pair_reg  <= '0;
      edges_reg <= '0;
    end else if (clr) begin
      cnt_reg   <= '0;
      tcl_reg   <= '0;
      pair_reg  <= '0;
      edges_reg <= '0;
    end else if (edge_pulse) begin
      cnt_reg   <= '0;
      tcl_reg   <= len;
      pair_reg  <= pair_w[W] ? '1 : pair_w[W-1:0];
      edges_reg <= W'(edges_reg + 1'b1);
    end else if (!sat) begin
      cnt_reg   <= W'(cnt_reg + 1'b1);
    end
  end

endmodule : phase_timer
`default_nettype wire

// *** verif/osc_model.sv ***
/*
  Free-running oscillator standing in for the clock source.
  Assumes mclk is the system clock; phase lengths are in mclk cycles, 2 or more.
*/
`timescale 1ns/1ps
`default_nettype none
module osc_model (
  input  wire logic       mclk,
  input  wire logic [3:0] hi_len,
  input  wire logic [3:0] lo_len,
  output logic            osc
);
  logic [3:0] cnt_reg;
  initial begin
    osc = 1'h0;
    cnt_reg = 4'h1;
  end
  // Runs free; uneven phases expose any duty-cycle leak into the CPU clock
  always @(posedge mclk) begin
    if (cnt_reg >= (osc ? hi_len : lo_len)) begin
      osc <= !osc;
      cnt_reg <= 4'h1;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : osc_model
`default_nettype wire

// *** verif/clkmode_sva.sv ***
/*
  Port checker for the CPU clock mode block.
  Assumes a single MCLK domain and RST_N low at the start of the run.
*/
`timescale 1ns/1ps
`default_nettype none
module clkmode_sva
  import clkmode_pkg::*;
(
  input wire logic          MCLK,
  input wire logic          RST_N,
  input wire logic          LONG_RESET,
  input wire logic [7:0]    PORT0_UPPER_BYTE,
  input wire logic          OSC_IN,
  input wire logic          PSEL,
  input wire logic          PENABLE,
  input wire logic [DW-1:0] PRDATA,
  input wire logic          PREADY,
  input wire logic          PSLVERR,
  input wire logic          CPU_CLK,
  input wire logic          PHASE_EDGE,
  input wire logic          PLL_DISABLE,
  input wire logic          DIRECT_MODE,
  input wire logic          MODE_VALID
);
  logic [2:0] quiet_reg;
  logic       pin7_reg;
  wire        run_ok = MODE_VALID && (quiet_reg == 3'h7);
  // Settling count after a long reset, so start-up is not judged
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) quiet_reg <= 3'h0;
    else if (LONG_RESET) quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
  end
  // Mode pin as last loaded
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) pin7_reg <= 1'h0;
    else if (LONG_RESET) pin7_reg <= PORT0_UPPER_BYTE[7];
  end
  ////////////////////////////////
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  direct_follow_a: assert property (run_ok && DIRECT_MODE |-> CPU_CLK == $past(OSC_IN))
    else $error("cpu clock not following oscillator");
  half_toggle_a: assert property (run_ok && !DIRECT_MODE && $rose(OSC_IN) |=>
    CPU_CLK != $past(CPU_CLK)) else $error("prescaled clock missed a toggle");
  half_hold_a: assert property (run_ok && !DIRECT_MODE && !$rose(OSC_IN) |=>
    $stable(CPU_CLK)) else $error("prescaled clock toggled early");
  edge_mark_a: assert property (PHASE_EDGE |-> CPU_CLK != $past(CPU_CLK))
    else $error("edge pulse without clock edge");
  pll_tie_a: assert property (MODE_VALID |-> PLL_DISABLE == DIRECT_MODE)
    else $error("pll disable disagrees with mode");
  mode_hold_a: assert property (run_ok |-> $stable(DIRECT_MODE))
    else $error("mode changed in operation");
  mode_load_a: assert property ($fell(LONG_RESET) |-> ##[1:3]
    (MODE_VALID && DIRECT_MODE == !pin7_reg)) else $error("mode not taken from pin");
  clk_stop_a: assert property (LONG_RESET [*3] |-> !CPU_CLK)
    else $error("cpu clock runs in long reset");
  apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("apb answer late or long");
  apb_err_a: assert property (PSLVERR || !PREADY |-> PRDATA == ZERO_WORD)
    else $error("read data not zero");
  cover property (run_ok && DIRECT_MODE);
  cover property (run_ok && !DIRECT_MODE);
  cover property (PSLVERR);
  cover property (PHASE_EDGE);
endmodule : clkmode_sva
bind cpu_clock_mode_select clkmode_sva u_sva (.MCLK(MCLK), .RST_N(RST_N),
  .LONG_RESET(LONG_RESET), .PORT0_UPPER_BYTE(PORT0_UPPER_BYTE), .OSC_IN(OSC_IN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CPU_CLK(CPU_CLK), .PHASE_EDGE(PHASE_EDGE), .PLL_DISABLE(PLL_DISABLE),
  .DIRECT_MODE(DIRECT_MODE), .MODE_VALID(MODE_VALID));
`default_nettype wire

// *** verif/tb_cpu_clock_mode_select.sv ***
/*
  Self-checking bench: APB register checks and mode loading.
  Assumes the oscillator model runs 3 high / 5 low MCLK cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_clock_mode_select
  import clkmode_pkg::*;
;
  logic          MCLK, RST_N, LONG_RESET, PSEL, PENABLE, PWRITE;
  logic [7:0]    PORT0_UPPER_BYTE;
  logic [AW-1:0] PADDR;
  logic [DW-1:0] PWDATA, PRDATA, rd;
  logic          PREADY, PSLVERR, CPU_CLK, PHASE_EDGE, PLL_DISABLE, DIRECT_MODE, MODE_VALID;
  logic          OSC_IN, er;
  int            bad_count, tests_run, cyc;
  logic [7:0]    pins[4] = '{8'h7F, 8'hA0, 8'h5A, 8'hFF};
  cpu_clock_mode_select uut (.MCLK(MCLK), .RST_N(RST_N), .LONG_RESET(LONG_RESET),
    .PORT0_UPPER_BYTE(PORT0_UPPER_BYTE), .OSC_IN(OSC_IN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CPU_CLK(CPU_CLK), .PHASE_EDGE(PHASE_EDGE),
    .PLL_DISABLE(PLL_DISABLE), .DIRECT_MODE(DIRECT_MODE), .MODE_VALID(MODE_VALID));
  osc_model osc_u (.mclk(MCLK), .hi_len(4'h3), .lo_len(4'h5), .osc(OSC_IN));
  ////////////////////////////////
  task automatic chk(input string what, input logic [DW-1:0] e, input logic [DW-1:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // APB master; an edge passes first so a release is never overwritten
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge MCLK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'h1;
    @(posedge MCLK);
    while (PREADY !== 1'h1) @(posedge MCLK);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask : apb
  task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] e);
    apb(1'h0, a, ZERO_WORD);
    chk("read data", e, rd & m);
    chk("read error", ZERO_WORD, {31'h0000_0000, er});
  endtask : rd_chk
  task automatic t_reset;
    rd_chk(OFS_CTRL, 32'h0000_0003, 32'h0000_0001);
    rd_chk(OFS_LATCH, 32'hFFFF_FFFF, ZERO_WORD);
    rd_chk(OFS_STATUS, 32'h0000_000F, ZERO_WORD);
    rd_chk(OFS_EDGES, 32'h0000_FFFF, ZERO_WORD);
  endtask : t_reset
  // Refused accesses must flag and leave the latch alone
  task automatic t_refuse;
    apb(1'h1, OFS_LATCH, 32'h0000_00FF);
    chk("ro write error", 32'h0000_0001, {31'h0000_0000, er});
    apb(1'h0, 8'h18, ZERO_WORD);
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, er});
    chk("unmapped data", ZERO_WORD, rd);
    rd_chk(OFS_LATCH, 32'hFFFF_FFFF, ZERO_WORD);
  endtask : t_refuse
  // Pins flip after loading; the mode must not follow them
  task automatic t_mode(input logic [7:0] p);
    logic [DW-1:0] st;
    st = p[7] ? 32'h0000_0008 : 32'h0000_000B;
    @(posedge MCLK);
    LONG_RESET <= 1'h1;
    PORT0_UPPER_BYTE <= p;
    repeat (4) @(posedge MCLK);
    LONG_RESET <= 1'h0;
    PORT0_UPPER_BYTE <= ~p;
    repeat (48) @(posedge MCLK);
    rd_chk(OFS_LATCH, 32'h0000_00FF, {24'h00_0000, p});
    rd_chk(OFS_STATUS, 32'h0000_000B, st);
    rd_chk(OFS_PAIR, 32'h0000_FFFF, p[7] ? 32'h0000_0010 : 32'h0000_0008);
    if (p[7]) rd_chk(OFS_TCL, 32'h0000_FFFF, 32'h0000_0008);
  endtask : t_mode
  // Edge strobe off, then on with a measure clear
  task automatic t_strobe;
    int n;
    n = 0;
    apb(1'h1, OFS_CTRL, ZERO_WORD);
    repeat (40) @(posedge MCLK) n += int'(PHASE_EDGE);
    chk("edges while off", ZERO_WORD, n);
    apb(1'h1, OFS_CTRL, 32'h0000_0003);
    rd_chk(OFS_CTRL, 32'h0000_0003, 32'h0000_0001);
    n = 0;
    repeat (40) @(posedge MCLK) n += int'(PHASE_EDGE);
    chk("edges while on", 32'h0000_0001, (n > 3));
    apb(1'h0, OFS_EDGES, ZERO_WORD);
    chk("edge count", 32'h0000_0001, (rd > 32'h0000_0003));
  endtask : t_strobe
  task automatic wrap_up;
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    MCLK = 1'h0;
    forever #5 MCLK = ~MCLK;
  end
  // Ceiling far above the roughly 370 cycles the sequence needs
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    {RST_N, LONG_RESET, PSEL, PENABLE, PWRITE} = 5'h00;
    {PORT0_UPPER_BYTE, PADDR, PWDATA} = '0;
    {bad_count, tests_run, cyc} = '0;
    repeat (3) @(posedge MCLK);
    RST_N <= 1'h1;
    t_reset();
    t_refuse();
    foreach (pins[i]) t_mode(pins[i]);
    t_strobe();
    wrap_up();
  end
endmodule : tb_cpu_clock_mode_select
`default_nettype wire
